// >>> ptc_timer.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ptc_timer
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // counter tick from clock selection logic
    input  wire logic        count_tick_in,
    // output pin, enable active low
    output logic             pin_out,
    output logic             pin_oe_n_out,
    // match flags
    output logic             match_a_flag_out,
    output logic             match_p_flag_out
);

    ptc_ctl_if ctl ();

    logic [7:0]  compare_a_low_byte;
    logic [1:0]  compare_a_high_bits;
    logic [7:0]  compare_p_low_byte;
    logic [1:0]  compare_p_high_bits;
    logic [8:0]  timer_control_one;
    logic        match_a_flag;
    logic        match_p_flag;
    logic        wr_take;
    logic        rd_take;
    logic        addr_ok;
    logic [31:0] next_rdata;
    ptc_pkg::ptc_bus_state_type bus_state;

    // ------------------------------------------------------------------
    // address check
    // ------------------------------------------------------------------
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == ptc_pkg::ADDR_CMP_A_LOW) || (a == ptc_pkg::ADDR_CMP_A_HIGH)
                   || (a == ptc_pkg::ADDR_CMP_P_LOW) || (a == ptc_pkg::ADDR_CMP_P_HIGH)
                   || (a == ptc_pkg::ADDR_CONTROL)   || (a == ptc_pkg::ADDR_FLAGS)
                   || (a == ptc_pkg::ADDR_COUNT);
    endfunction

    // ------------------------------------------------------------------
    // apb handshake: one wait state, answer in second access cycle
    // ------------------------------------------------------------------
    assign addr_ok = addr_mapped(paddr_in);
    assign wr_take = psel_in & penable_in & pready_out & pwrite_in & addr_ok;
    assign rd_take = psel_in & penable_in & ~pready_out & ~pwrite_in;

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
            bus_state <= ptc_pkg::BUS_IDLE;
        else if (psel_in && penable_in && bus_state == ptc_pkg::BUS_IDLE)
            bus_state <= ptc_pkg::BUS_ACCESS;
        else
            bus_state <= ptc_pkg::BUS_IDLE;
    end

    assign pready_out  = (bus_state == ptc_pkg::BUS_ACCESS);
    assign pslverr_out = pready_out & ~addr_ok;

    // read mux
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (paddr_in)
            ptc_pkg::ADDR_CMP_A_LOW:  next_rdata[7:0] = compare_a_low_byte;
            ptc_pkg::ADDR_CMP_A_HIGH: next_rdata[1:0] = compare_a_high_bits;
            ptc_pkg::ADDR_CMP_P_LOW:  next_rdata[7:0] = compare_p_low_byte;
            ptc_pkg::ADDR_CMP_P_HIGH: next_rdata[1:0] = compare_p_high_bits;
            ptc_pkg::ADDR_CONTROL:    next_rdata[8:0] = timer_control_one;
            ptc_pkg::ADDR_FLAGS:
            begin
                next_rdata[ptc_pkg::FLAG_A_BIT] = match_a_flag;
                next_rdata[ptc_pkg::FLAG_P_BIT] = match_p_flag;
            end
            ptc_pkg::ADDR_COUNT:      next_rdata[9:0] = ctl.count;
            default:                  next_rdata = 32'h0000_0000;
        endcase
    end

    // read data register
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
            prdata_out <= 32'h0000_0000;
        else if (rd_take)
            prdata_out <= next_rdata;
    end

    // ------------------------------------------------------------------
    // compare value registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            compare_a_low_byte  <= ptc_pkg::BYTE_RESET;
            compare_a_high_bits <= ptc_pkg::BYTE_RESET[1:0];
            compare_p_low_byte  <= ptc_pkg::BYTE_RESET;
            compare_p_high_bits <= ptc_pkg::BYTE_RESET[1:0];
        end
        else if (wr_take && pstrb_in[0])
        begin
            case (paddr_in)
                ptc_pkg::ADDR_CMP_A_LOW:  compare_a_low_byte  <= pwdata_in[7:0];
                ptc_pkg::ADDR_CMP_A_HIGH: compare_a_high_bits <= pwdata_in[1:0];
                ptc_pkg::ADDR_CMP_P_LOW:  compare_p_low_byte  <= pwdata_in[7:0];
                ptc_pkg::ADDR_CMP_P_HIGH: compare_p_high_bits <= pwdata_in[1:0];
                default:                  compare_a_low_byte  <= compare_a_low_byte;
            endcase
        end
    end

    // control register, spans two byte lanes
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
            timer_control_one <= ptc_pkg::CTL_RESET;
        else if (wr_take && paddr_in == ptc_pkg::ADDR_CONTROL)
        begin
            if (pstrb_in[0])
                timer_control_one[7:0] <= pwdata_in[7:0];
            if (pstrb_in[1])
                timer_control_one[8] <= pwdata_in[ptc_pkg::CTL_ON_BIT];
        end
    end

    // ------------------------------------------------------------------
    // sticky flags, write one to clear, set beats clear
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end
        else
        begin
            if (ctl.match_a)
                match_a_flag <= 1'b1;
            else if (wr_take && pstrb_in[0] && paddr_in == ptc_pkg::ADDR_FLAGS
                     && pwdata_in[ptc_pkg::FLAG_A_BIT])
                match_a_flag <= 1'b0;
            if (ctl.match_p)
                match_p_flag <= 1'b1;
            else if (wr_take && pstrb_in[0] && paddr_in == ptc_pkg::ADDR_FLAGS
                     && pwdata_in[ptc_pkg::FLAG_P_BIT])
                match_p_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // control bundle to the core
    // ------------------------------------------------------------------
    assign ctl.compare_a_value      = {compare_a_high_bits, compare_a_low_byte};
    assign ctl.compare_p_value      = {compare_p_high_bits, compare_p_low_byte};
    assign ctl.mode                 = {timer_control_one[ptc_pkg::CTL_MODE_HI_BIT],
                                       timer_control_one[ptc_pkg::CTL_MODE_LO_BIT]};
    assign ctl.pin_action           = {timer_control_one[ptc_pkg::CTL_ACT_HI_BIT],
                                       timer_control_one[ptc_pkg::CTL_ACT_LO_BIT]};
    assign ctl.clear_source_select  = timer_control_one[ptc_pkg::CTL_CLR_SRC_BIT];
    assign ctl.output_initial_level = timer_control_one[ptc_pkg::CTL_INIT_BIT];
    assign ctl.output_invert        = timer_control_one[ptc_pkg::CTL_INVERT_BIT];
    assign ctl.counter_on           = timer_control_one[ptc_pkg::CTL_ON_BIT];
    assign ctl.count_enable         = count_tick_in;

    ptc_core u_core
    (
        .clock_in (clock_in),
        .reset_in (reset_in),
        .ctl      (ctl)
    );

    // pin outputs
    assign pin_out          = ctl.pin_level;
    assign pin_oe_n_out     = ~ctl.pin_drive;
    assign match_a_flag_out = match_a_flag;
    assign match_p_flag_out = match_p_flag;

endmodule

// >>> ptc_pkg.sv
package ptc_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CMP_A_LOW   = 8'h00;
    localparam logic [7:0] ADDR_CMP_A_HIGH  = 8'h04;
    localparam logic [7:0] ADDR_CMP_P_LOW   = 8'h08;
    localparam logic [7:0] ADDR_CMP_P_HIGH  = 8'h0c;
    localparam logic [7:0] ADDR_CONTROL     = 8'h10;
    localparam logic [7:0] ADDR_FLAGS       = 8'h14;
    localparam logic [7:0] ADDR_COUNT       = 8'h18;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTL_ON_BIT        = 8;
    localparam int CTL_MODE_HI_BIT   = 7;
    localparam int CTL_MODE_LO_BIT   = 6;
    localparam int CTL_ACT_HI_BIT    = 5;
    localparam int CTL_ACT_LO_BIT    = 4;
    localparam int CTL_INIT_BIT      = 3;
    localparam int CTL_INVERT_BIT    = 2;
    localparam int CTL_CLR_SRC_BIT   = 0;
    localparam int CTL_WIDTH         = 9;
    localparam logic [8:0] CTL_RESET = 9'h000;

    // flag register fields (write one to clear)
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;

    // widths and reset values
    localparam int CMP_WIDTH          = 10;
    localparam int HIGH_BITS          = 2;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ------------------------------------------------------------------
    // operating modes and pin actions
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_PWM     = 2'h2,
        MODE_TIMER   = 2'h3
    } ptc_mode_type;

    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    localparam logic [1:0] PWM_FORCE_INACTIVE = 2'h0;
    localparam logic [1:0] PWM_FORCE_ACTIVE   = 2'h1;
    localparam logic [1:0] PWM_WAVE           = 2'h2;

    // apb answer state
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'h0,
        BUS_ACCESS = 2'h1
    } ptc_bus_state_type;

endpackage

// >>> ptc_ctl_if.sv
`timescale 1ns/1ps
// control bundle from register file to the compare core
interface ptc_ctl_if;
    logic [9:0] compare_a_value;
    logic [9:0] compare_p_value;
    logic [1:0] mode;
    logic [1:0] pin_action;
    logic       clear_source_select;
    logic       output_initial_level;
    logic       output_invert;
    logic       counter_on;
    logic       count_enable;
    logic [9:0] count;
    logic       match_a;
    logic       match_p;
    logic       pin_level;
    logic       pin_drive;

    modport regs
    (
        output compare_a_value, compare_p_value, mode, pin_action,
        output clear_source_select, output_initial_level, output_invert,
        output counter_on, count_enable,
        input  count, match_a, match_p, pin_level, pin_drive
    );
    modport core
    (
        input  compare_a_value, compare_p_value, mode, pin_action,
        input  clear_source_select, output_initial_level, output_invert,
        input  counter_on, count_enable,
        output count, match_a, match_p, pin_level, pin_drive
    );
endinterface

// >>> ptc_core.sv
`timescale 1ns/1ps
// counter, comparators and output pin logic
module ptc_core
(
    // clock and reset
    input  wire logic clock_in,
    input  wire logic reset_in,
    // control bundle
    ptc_ctl_if.core   ctl
);

    logic       on_prev;
    logic       on_rise;
    logic       pin_state;
    logic [9:0] pwm_period;
    logic       is_pwm;
    logic       hit_a;
    logic       hit_p;
    logic       clr_on_a;
    logic       clr_on_p;
    logic       wave_active;

    // -----------------------------------------------------------------
    // comparators
    // -----------------------------------------------------------------
    assign on_rise  = ctl.counter_on & ~on_prev;
    assign is_pwm   = (ctl.mode == ptc_pkg::MODE_PWM);
    assign hit_a    = ctl.counter_on & ctl.count_enable & (ctl.count == ctl.compare_a_value);
    // p comparator: zero value matches at overflow (wrap to zero)
    assign hit_p    = ctl.counter_on & ctl.count_enable
                      & (ctl.count == ctl.compare_p_value - 10'h001);
    assign clr_on_a = ~is_pwm & ctl.clear_source_select;
    assign clr_on_p = is_pwm | ~ctl.clear_source_select;
    // match pulses toward flag logic
    assign ctl.match_a = hit_a;
    assign ctl.match_p = hit_p & clr_on_p;

    // rising edge memory of counter_on
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
            on_prev <= 1'b0;
        else
            on_prev <= ctl.counter_on;
    end

    // -----------------------------------------------------------------
    // counter
    // -----------------------------------------------------------------
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
            ctl.count <= 10'h000;
        else if (on_rise)
            ctl.count <= 10'h000;
        else if (ctl.counter_on && ctl.count_enable)
        begin
            if ((clr_on_a && hit_a) || (clr_on_p && hit_p))
                ctl.count <= 10'h000;
            else
                ctl.count <= ctl.count + 10'h001;
        end
    end

    // -----------------------------------------------------------------
    // compare match pin state
    // -----------------------------------------------------------------
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
            pin_state <= 1'b0;
        else if (on_rise)
            pin_state <= ctl.output_initial_level;
        else if (ctl.mode == ptc_pkg::MODE_COMPARE && hit_a)
        begin
            case (ctl.pin_action)
                ptc_pkg::ACT_LOW:    pin_state <= 1'b0;
                ptc_pkg::ACT_HIGH:   pin_state <= 1'b1;
                ptc_pkg::ACT_TOGGLE: pin_state <= ~pin_state;
                default:             pin_state <= pin_state;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // pwm: p sets period (zero gives 1024), a sets duty
    // -----------------------------------------------------------------
    assign pwm_period  = ctl.compare_p_value;
    assign wave_active = (pwm_period == 10'h000) ? 1'b1 : 1'b0;

    // pin level and drive, registered
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ctl.pin_level <= 1'b0;
            ctl.pin_drive <= 1'b0;
        end
        else
        begin
            ctl.pin_drive <= (ctl.mode != ptc_pkg::MODE_TIMER)
                             && (ctl.mode != ptc_pkg::MODE_CAPTURE);
            case (ctl.mode)
                ptc_pkg::MODE_PWM:
                begin
                    case (ctl.pin_action)
                        ptc_pkg::PWM_FORCE_INACTIVE:
                            ctl.pin_level <= ~ctl.output_initial_level ^ ctl.output_invert;
                        ptc_pkg::PWM_FORCE_ACTIVE:
                            ctl.pin_level <= ctl.output_initial_level ^ ctl.output_invert;
                        default:
                            // duty a vs period p; a >= p gives 100% for nonzero p
                            ctl.pin_level <= ((({1'b0, ctl.count} < {1'b0, ctl.compare_a_value})
                                              || (!wave_active
                                                  && ctl.compare_a_value >= pwm_period))
                                              ? ctl.output_initial_level
                                              : ~ctl.output_initial_level)
                                             ^ ctl.output_invert;
                    endcase
                end
                default:
                    ctl.pin_level <= pin_state ^ ctl.output_invert;
            endcase
        end
    end

endmodule

// >>> ptc_pin_load.sv
`timescale 1ns/1ps
// external load on the timer output pin, with a pull-up on the line
module ptc_pin_load
(
    // clock
    input  wire logic        clock_in,
    // pin from the timer
    input  wire logic        pin_in,
    input  wire logic        pin_oe_n_in,
    // duty measurement
    input  wire logic        sample_in,
    output logic             level_out,
    output logic      [10:0] high_count_out
);
    // released line is pulled high
    assign level_out = pin_oe_n_in ? 1'b1 : pin_in;

    // count high cycles while sampling, clear otherwise
    always_ff @(posedge clock_in)
    begin
        if (!sample_in)
            high_count_out <= 11'h000;
        else if (level_out)
            high_count_out <= high_count_out + 11'h001;
    end
endmodule

// >>> ptc_timer_monitor.sv
`timescale 1ns/1ps
// port checker for the timer block
module ptc_timer_monitor
(
    // clock and reset
    input wire logic        clock_in,
    input wire logic        reset_in,
    // apb slave
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0]  pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    // timer side
    input wire logic        count_tick_in,
    input wire logic        pin_out,
    input wire logic        pin_oe_n_out,
    input wire logic        match_a_flag_out,
    input wire logic        match_p_flag_out
);
    logic [8:0] ctl;
    logic [2:0] age;
    logic [1:0] mode;
    logic       done;
    logic       fl_wr;
    logic       steady;

    // ------------------------------
    // control shadow
    // ------------------------------
    // completed writes and settled configuration
    assign done   = psel_in & penable_in & pready_out & pwrite_in;
    assign fl_wr  = done & (paddr_in == ptc_pkg::ADDR_FLAGS) & pstrb_in[0];
    assign mode   = ctl[7:6];
    assign steady = age >= 3'h3;

    // copy of control and cycles since it was written
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ctl <= ptc_pkg::CTL_RESET;
            age <= 3'h0;
        end
        else if (done && paddr_in == ptc_pkg::ADDR_CONTROL)
        begin
            ctl <= {pstrb_in[1] ? pwdata_in[8] : ctl[8], pstrb_in[0] ? pwdata_in[7:0] : ctl[7:0]};
            age <= 3'h0;
        end
        else if (age != 3'h7)
            age <= age + 3'h1;
    end

    // ------------------------------
    // checks
    // ------------------------------
    default clocking mon_cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);

    pready_wait_a: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
        else $error("pready not in second access cycle");
    flag_a_hold_a: assert property ($fell(match_a_flag_out) |-> $past(fl_wr && pwdata_in[0]))
        else $error("flag a dropped without clear");
    flag_p_hold_a: assert property ($fell(match_p_flag_out) |-> $past(fl_wr && pwdata_in[1]))
        else $error("flag p dropped without clear");
    p_flag_block_a: assert property (steady && mode == 2'h0 && ctl[0] |-> !$rose(match_p_flag_out))
        else $error("p flag raised while a clears");
    timer_no_drive_a: assert property (steady && mode == 2'h3 |-> pin_oe_n_out)
        else $error("pin driven in timer mode");
    pin_drive_a: assert property (steady && !mode[0] |-> !pin_oe_n_out)
        else $error("pin not driven in output mode");
    pwm_force_a: assert property (steady && ctl[8] && mode == 2'h2 && !ctl[5]
        |-> pin_out == ((ctl[4] ~^ ctl[3]) ^ ctl[2]))
        else $error("forced pwm level wrong");
    on_load_a: assert property ($rose(ctl[8]) && mode == 2'h0 |-> ##[1:2] pin_out == (ctl[3] ^ ctl[2]))
        else $error("pin not loaded at start");
    cmp_pin_hold_a: assert property (steady && mode == 2'h0 && $changed(pin_out) |-> match_a_flag_out)
        else $error("pin moved without a match");

    pwm_run_c: cover property (steady && ctl[8] && mode == 2'h2);
    clr_a_c: cover property (steady && ctl[0] && mode == 2'h0 && $rose(match_a_flag_out));
    flag_clr_c: cover property ($fell(match_a_flag_out));
endmodule

bind ptc_timer ptc_timer_monitor mon (.clock_in, .reset_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .count_tick_in,
    .pin_out, .pin_oe_n_out, .match_a_flag_out, .match_p_flag_out);

// >>> ptc_timer_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the timer block
module ptc_timer_tb_top;
    logic        clock_in;
    logic        reset_in      = 1'b1;
    logic        psel_in       = 1'b0;
    logic        penable_in    = 1'b0;
    logic        pwrite_in     = 1'b0;
    logic [7:0]  paddr_in      = 8'h00;
    logic [31:0] pwdata_in     = 32'h0;
    logic [3:0]  pstrb_in      = 4'hf;
    logic        count_tick_in = 1'b1;
    logic        sample        = 1'b0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        pin_out;
    logic        pin_oe_n_out;
    logic        match_a_flag_out;
    logic        match_p_flag_out;
    logic        level;
    logic [10:0] high_count;
    logic        slv_err;
    int          err_count = 0;
    int          checked   = 0;

    ptc_timer DUT (.clock_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .count_tick_in,
        .pin_out, .pin_oe_n_out, .match_a_flag_out, .match_p_flag_out);
    ptc_pin_load load (.clock_in, .pin_in(pin_out), .pin_oe_n_in(pin_oe_n_out),
        .sample_in(sample), .level_out(level), .high_count_out(high_count));

    // 250 MHz clock
    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    // ------------------------------
    // helpers
    // ------------------------------
    task automatic run(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock_in);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge clock_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 50);
        if (n >= 50)
            chk(32'h0, 32'h1);
        q = prdata_out;
        slv_err = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        apb(1'b0, a, 32'h0, q);
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] act,
                                        input logic ini, input logic inv, input logic clr);
        return {23'h0, 1'b0, m, act, ini, inv, 1'b0, clr};
    endfunction

    task automatic set_ab(input logic [9:0] a, input logic [9:0] p);
        wr(ptc_pkg::ADDR_CMP_A_LOW, {24'h0, a[7:0]});
        wr(ptc_pkg::ADDR_CMP_A_HIGH, {30'h0, a[9:8]});
        wr(ptc_pkg::ADDR_CMP_P_LOW, {24'h0, p[7:0]});
        wr(ptc_pkg::ADDR_CMP_P_HIGH, {30'h0, p[9:8]});
    endtask

    // stop, clear flags, then restart the counter
    task automatic start(input logic [31:0] c);
        wr(ptc_pkg::ADDR_CONTROL, c);
        wr(ptc_pkg::ADDR_FLAGS, 32'h3);
        wr(ptc_pkg::ADDR_CONTROL, c | 32'h100);
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_regs();
        logic [31:0] q;
        for (int i = 0; i < 4; i++)
        begin
            rd(8'(i * 4), q);
            chk(q, 32'h0);
            wr(8'(i * 4), 32'hff);
            rd(8'(i * 4), q);
            chk(q, i[0] ? 32'h3 : 32'hff);
        end
        rd(8'h1c, q);
        chk(32'(slv_err), 32'h1);
        $display("register test done");
    endtask

    task automatic t_cmp();
        logic [31:0] q;
        logic        ini;
        logic        ex;
        set_ab(10'h5, 10'ha); // nonzero A in compare mode
        for (int k = 0; k < 4; k++)
        begin
            ini = (k == 1);
            ex  = (k == 0) ? ini : (k != 1);
            start(ctl(2'h0, 2'(k), ini, 1'b0, 1'b0));
            run(10);
            chk(32'(level), 32'(ex));
        end
        // p match at count nine lands two edges later
        run(2);
        chk(32'({match_a_flag_out, match_p_flag_out}), 32'h3);
        rd(ptc_pkg::ADDR_COUNT, q);
        chk(32'(q < 32'ha), 32'h1);
        $display("compare test done");
    endtask

    task automatic t_clr_a();
        logic [31:0] q;
        set_ab(10'h6, 10'h3);
        start(ctl(2'h0, ptc_pkg::ACT_TOGGLE, 1'b0, 1'b0, 1'b1));
        run(40);
        chk(32'({match_a_flag_out, match_p_flag_out}), 32'h2);
        rd(ptc_pkg::ADDR_COUNT, q);
        chk(32'(q < 32'h7), 32'h1);
        $display("clear on a test done");
    endtask

    task automatic t_ovf();
        set_ab(10'h2bc, 10'h0);
        start(ctl(2'h0, ptc_pkg::ACT_NONE, 1'b0, 1'b0, 1'b0));
        run(1000);
        chk(32'(match_p_flag_out), 32'h0);
        run(40);
        chk(32'(match_p_flag_out), 32'h1);
        $display("overflow test done");
    endtask

    task automatic t_timer();
        logic [31:0] q;
        logic [31:0] r;
        set_ab(10'h5, 10'ha);
        start(ctl(2'h3, 2'h0, 1'b0, 1'b0, 1'b0));
        run(30);
        chk(32'({pin_oe_n_out, level, match_a_flag_out, match_p_flag_out}), 32'hf);
        wr(ptc_pkg::ADDR_CONTROL, ctl(2'h3, 2'h0, 1'b0, 1'b0, 1'b0));
        rd(ptc_pkg::ADDR_COUNT, q);
        run(10);
        rd(ptc_pkg::ADDR_COUNT, r);
        chk(r, q);
        chk(32'({match_a_flag_out, match_p_flag_out}), 32'h3);
        count_tick_in <= 1'b0;
        wr(ptc_pkg::ADDR_CONTROL, 32'h1c0);
        rd(ptc_pkg::ADDR_COUNT, q);
        chk(q, 32'h0);
        wr(ptc_pkg::ADDR_FLAGS, 32'h1);
        run(1);
        chk(32'({match_a_flag_out, match_p_flag_out}), 32'h1);
        count_tick_in <= 1'b1;
        $display("timer test done");
    endtask

    task automatic t_pwm();
        logic [11:0] tp [7] = '{12'h8, 12'h8, 12'h8, 12'h8, 12'h8, 12'h8, 12'h0};
        logic [11:0] ta [7] = '{12'h2, 12'h2, 12'h2, 12'h9, 12'h2, 12'h2, 12'h200};
        logic [1:0]  tc [7] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h2};
        logic [1:0]  tv [7] = '{2'h2, 2'h3, 2'h0, 2'h2, 2'h2, 2'h1, 2'h2};
        logic [11:0] te [7] = '{12'h2, 12'h6, 12'h6, 12'h8, 12'h0, 12'h8, 12'h200};
        int          w;
        for (int i = 0; i < 7; i++)
        begin
            set_ab(ta[i][9:0], tp[i][9:0]);
            start(ctl(2'h2, tc[i], tv[i][1], tv[i][0], 1'b1));
            w = (tp[i] == 12'h0) ? 1024 : int'(tp[i]);
            run(w + 4);
            sample <= 1'b1;
            run(w);
            sample <= 1'b0;
            run(1);
            chk(32'(high_count), 32'(te[i]));
        end
        chk(32'({match_a_flag_out, match_p_flag_out}), 32'h3);
        $display("pwm test done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge clock_in);
        reset_in <= 1'b0;
        t_regs();
        t_cmp();
        t_clr_a();
        t_ovf();
        t_timer();
        t_pwm();
        print_verdict();
    end

    // cut a hung run short
    initial
    begin
        #100000;
        err_count++;
        $display("BAD %0t run took too long", $time);
        print_verdict();
    end
endmodule
